// ### src/cig_regs.vh
// Notes on behaviour
// - Any write to the interrupt-clear register drops a pending serial line request.
// - Read error and both counter requests clear when their own field is written zero.
// - After the cache loads from boot ROM, the serial input bit follows the data pin.
// - Once the cache has loaded, every rising or falling edge on the serial input sets the serial request.
// - With the serial enable low, no serial line interrupt is raised.
// - Any write to full zap invalidates all twelve entries and resets the victim pointer.
// - Any write to non-global invalidate clears only entries whose global flag is zero.
// - Any write to single invalidate also clears all twelve entries and resets the pointer.
// - The status register holds only the two mode bits; others ignored and read zero.
// - Each arithmetic trap sets its summary flag; flags accumulate until the next write.
// - The trapping destination register is recorded as one bit of a 64-bit mask.
// - Each summary read shows the next mask bit, floats 31..0 then integers, and clears it.
// - Any summary write clears flags 8 down to 2 and leaves the write mask alone.
// - Mask bit clears and shifts three cycles after a read; reads need four cycles apart.
// - Summary bit 33 shows the current mask bit, cleared as a side effect of reading.
// - Flags: 8 integer overflow, 7 inexact, 6 underflow, 5 overflow, 4 divide zero, 3 invalid.
// - Bit 2 sets on a soft-completion float trap when all float traps since write had it.
// - A float trap without soft completion clears bit 2 until the next summary write.
// - A summary write leaves the soft-completion flag cleared unless a soft-completion float trap arrives in the same cycle.
// - The serial line request reads at bit 13 of the interrupt request register.
// - The read error request shows at bit 4 and holds until cleared.
`ifndef CIG_REGS_VH
`define CIG_REGS_VH

// Internal register select codes.
`define CIG_SEL_IRQ_CLEAR 4'h0
`define CIG_SEL_SERIAL_IN 4'h1
`define CIG_SEL_FULL_ZAP 4'h2
`define CIG_SEL_NONGLOBAL_INV 4'h3
`define CIG_SEL_SINGLE_INV 4'h4
`define CIG_SEL_MODE_STATUS 4'h5
`define CIG_SEL_TRAP_SUMMARY 4'h6
`define CIG_SEL_IRQ_REQUEST 4'h7

// Interrupt-clear fields; counter and read error fields clear on zero, serial on any write.
`define CIG_CLR_PC1_BIT 0
`define CIG_CLR_PC0_BIT 1
`define CIG_CLR_CRD_BIT 2
`define CIG_CLR_SLC_BIT 32

// Interrupt request register positions.
`define CIG_IRR_SERIAL_BIT 13
`define CIG_IRR_PC0_BIT 9
`define CIG_IRR_PC1_BIT 8
`define CIG_IRR_CRD_BIT 4

// Serial input register position.
`define CIG_SERIAL_IN_BIT 0

// Processor status mode bit positions.
`define CIG_MODE_HI_BIT 4
`define CIG_MODE_LO_BIT 3
`define CIG_MODE_RESET 2'h0

// Trap summary positions.
`define CIG_SUM_MASK_BIT 33
`define CIG_SUM_FLAG_HI 8
`define CIG_SUM_FLAG_LO 3
`define CIG_SUM_SWC_BIT 2

// Write mask: bit 63 is float 31, bit 32 float 0, bit 31 integer 31, bit 0 integer 0.
`define CIG_MASK_START 6'h3f
`define CIG_MASK_CLEAR_DELAY 3

// Translation buffer.
`define CIG_TB_ENTRIES 12
`define CIG_TB_PTR_RESET 4'h0

`endif

// ### src/cig_sync.v
module cig_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset.
	input wire clk_sys_in,
	input wire rst_in,
	// Asynchronous level in, synchronised level out.
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ### src/cig_ipr_group.v
`include "cig_regs.vh"

module cig_ipr_group #(
	parameter TB_ENTRIES = `CIG_TB_ENTRIES,
	parameter CLEAR_DELAY = `CIG_MASK_CLEAR_DELAY
) (
	// Clock and reset.
	input wire clk_sys_in,
	input wire rst_in,
	// Internal register access from move-to and move-from instructions.
	input wire ipr_wr_en_in,
	input wire ipr_rd_en_in,
	input wire [3:0] ipr_sel_in,
	input wire [63:0] ipr_wdata_in,
	output reg [63:0] ipr_rdata_out,
	output reg ipr_rd_valid_out,
	// Serial line pins and status.
	input wire boot_rom_data_pin_in,
	input wire icache_loaded_in,
	input wire serial_irq_enable_in,
	// Other interrupt sources.
	input wire crd_event_in,
	input wire pc0_event_in,
	input wire pc1_event_in,
	// Interrupt requests.
	output reg serial_irq_status_bit_out,
	output reg serial_irq_out,
	output reg corrected_err_irq_status_out,
	output reg perf_count0_irq_out,
	output reg perf_count1_irq_out,
	// Arithmetic trap reports.
	input wire trap_valid_in,
	input wire [5:0] trap_flags_in,
	input wire trap_is_float_in,
	input wire trap_soft_in,
	input wire [5:0] trap_dest_in,
	// Translation buffer fill and state.
	input wire tb_fill_in,
	input wire tb_fill_global_in,
	output reg [TB_ENTRIES-1:0] tb_valid_out,
	output reg [TB_ENTRIES-1:0] tb_global_out,
	output reg [3:0] next_victim_pointer_out,
	// Current mode.
	output reg [1:0] cur_mode_out
);
	wire wr_clear;
	wire wr_zap;
	wire wr_nonglobal;
	wire wr_single;
	wire wr_mode;
	wire wr_summary;
	wire rd_summary;
	wire serial_sync;

	reg serial_prev_ff;

	reg serial_in_bit_ff;
	reg serial_req_ff;
	reg crd_req_ff;
	reg pc0_req_ff;
	reg pc1_req_ff;
	reg [5:0] trap_sum_ff;
	reg swc_ff;
	reg swc_ok_ff;
	reg [63:0] wmask_ff;
	reg [5:0] mask_ptr_ff;
	reg [CLEAR_DELAY-1:0] rd_pipe_ff;

	reg [63:0] nxt_rdata;
	reg [5:0] nxt_trap_sum;
	reg nxt_swc;
	reg nxt_swc_ok;
	reg [63:0] nxt_wmask;
	reg [TB_ENTRIES-1:0] nxt_tb_valid;
	reg [TB_ENTRIES-1:0] nxt_tb_global;
	reg [3:0] nxt_victim;

	wire serial_edge;
	wire tb_flush_all;

	// Strobes are decoded once, so every block acts on the same select.
	assign wr_clear = ipr_wr_en_in && (ipr_sel_in == `CIG_SEL_IRQ_CLEAR);
	assign wr_zap = ipr_wr_en_in && (ipr_sel_in == `CIG_SEL_FULL_ZAP);
	assign wr_nonglobal = ipr_wr_en_in && (ipr_sel_in == `CIG_SEL_NONGLOBAL_INV);
	assign wr_single = ipr_wr_en_in && (ipr_sel_in == `CIG_SEL_SINGLE_INV);
	assign wr_mode = ipr_wr_en_in && (ipr_sel_in == `CIG_SEL_MODE_STATUS);
	assign wr_summary = ipr_wr_en_in && (ipr_sel_in == `CIG_SEL_TRAP_SUMMARY);
	assign rd_summary = ipr_rd_en_in && (ipr_sel_in == `CIG_SEL_TRAP_SUMMARY);
	assign tb_flush_all = wr_zap || wr_single;

	// The boot ROM data pin is asynchronous to the core clock.
	cig_sync #(
		.WIDTH(1)
	) u_serial_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.async_in(boot_rom_data_pin_in),
		.sync_out(serial_sync)
	);

	// Edges are only taken once the pin belongs to the serial line.
	// The detector resets to the idle low level, so reset release gives no false edge.
	assign serial_edge = icache_loaded_in && (serial_sync != serial_prev_ff);

	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			serial_prev_ff <= 1'b0;
			serial_in_bit_ff <= 1'b0;
		end else begin
			serial_prev_ff <= serial_sync;
			serial_in_bit_ff <= icache_loaded_in & serial_sync;
		end
	end

	// Interrupt requests: a new event in the clearing cycle wins.
	// Only the serial request ignores the data; the others need their field at zero.
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			serial_req_ff <= 1'b0;
			crd_req_ff <= 1'b0;
			pc0_req_ff <= 1'b0;
			pc1_req_ff <= 1'b0;
		end else begin
			if (serial_edge)
				serial_req_ff <= 1'b1;
			else if (wr_clear)
				serial_req_ff <= 1'b0;
			if (crd_event_in)
				crd_req_ff <= 1'b1;
			else if (wr_clear && !ipr_wdata_in[`CIG_CLR_CRD_BIT])
				crd_req_ff <= 1'b0;
			if (pc0_event_in)
				pc0_req_ff <= 1'b1;
			else if (wr_clear && !ipr_wdata_in[`CIG_CLR_PC0_BIT])
				pc0_req_ff <= 1'b0;
			if (pc1_event_in)
				pc1_req_ff <= 1'b1;
			else if (wr_clear && !ipr_wdata_in[`CIG_CLR_PC1_BIT])
				pc1_req_ff <= 1'b0;
		end
	end

	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			serial_irq_status_bit_out <= 1'b0;
			serial_irq_out <= 1'b0;
			corrected_err_irq_status_out <= 1'b0;
			perf_count0_irq_out <= 1'b0;
			perf_count1_irq_out <= 1'b0;
		end else begin
			// One extra flop keeps every output on a register, at one cycle of latency.
			serial_irq_status_bit_out <= serial_req_ff;
			serial_irq_out <= serial_req_ff & serial_irq_enable_in;
			corrected_err_irq_status_out <= crd_req_ff;
			perf_count0_irq_out <= pc0_req_ff;
			perf_count1_irq_out <= pc1_req_ff;
		end
	end

	// Mode status keeps only the two mode bits.
	// Other write bits are dropped here, so reads return zero outside the mode field.
	always @(posedge clk_sys_in) begin
		if (rst_in)
			cur_mode_out <= `CIG_MODE_RESET;
		else if (wr_mode)
			cur_mode_out <= {ipr_wdata_in[`CIG_MODE_HI_BIT],
				ipr_wdata_in[`CIG_MODE_LO_BIT]};
	end

	// Trap summary and soft-completion tracking.
	// The qualifier state survives reads, so only a summary write restores it.
	always @* begin
		nxt_trap_sum = trap_sum_ff;
		nxt_swc = swc_ff;
		nxt_swc_ok = swc_ok_ff;
		if (wr_summary) begin
			nxt_trap_sum = 6'h00;
			nxt_swc = 1'b0;
			nxt_swc_ok = 1'b1;
		end
		if (trap_valid_in) begin
			nxt_trap_sum = nxt_trap_sum | trap_flags_in;
			if (trap_is_float_in) begin
				if (trap_soft_in) begin
					nxt_swc = nxt_swc_ok;
				end else begin
					nxt_swc = 1'b0;
					nxt_swc_ok = 1'b0;
				end
			end
		end
	end

	// Write mask: the clear lands a fixed delay after the read that saw the bit.
	// A new trap to the bit being cleared wins, so that result is not lost.
	always @* begin
		nxt_wmask = wmask_ff;
		if (rd_pipe_ff[CLEAR_DELAY-1])
			nxt_wmask[mask_ptr_ff] = 1'b0;
		if (trap_valid_in)
			nxt_wmask[trap_dest_in] = 1'b1;
	end

	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			trap_sum_ff <= 6'h00;
			swc_ff <= 1'b0;
			swc_ok_ff <= 1'b1;
			wmask_ff <= 64'h0000_0000_0000_0000;
			mask_ptr_ff <= `CIG_MASK_START;
			rd_pipe_ff <= {CLEAR_DELAY{1'b0}};
		end else begin
			trap_sum_ff <= nxt_trap_sum;
			swc_ff <= nxt_swc;
			swc_ok_ff <= nxt_swc_ok;
			wmask_ff <= nxt_wmask;
			rd_pipe_ff <= {rd_pipe_ff[CLEAR_DELAY-2:0], rd_summary};
			// Pointer walks float 31 down to integer 0, then wraps.
			// Reads no farther apart than the delay see the same bit again; software must space them.
			if (rd_pipe_ff[CLEAR_DELAY-1])
				mask_ptr_ff <= mask_ptr_ff - 6'h01;
		end
	end

	// Translation buffer valid bits; a command beats a fill in the same cycle.
	// A fill lost that way must be repeated; the pointer wraps at the last entry.
	always @* begin
		nxt_tb_valid = tb_valid_out;
		nxt_tb_global = tb_global_out;
		nxt_victim = next_victim_pointer_out;
		if (tb_fill_in) begin
			nxt_tb_valid[next_victim_pointer_out] = 1'b1;
			nxt_tb_global[next_victim_pointer_out] = tb_fill_global_in;
			if (next_victim_pointer_out == TB_ENTRIES - 1)
				nxt_victim = `CIG_TB_PTR_RESET;
			else
				nxt_victim = next_victim_pointer_out + 4'h1;
		end
		if (wr_nonglobal)
			nxt_tb_valid = nxt_tb_valid & nxt_tb_global;
		if (tb_flush_all) begin
			nxt_tb_valid = {TB_ENTRIES{1'b0}};
			nxt_victim = `CIG_TB_PTR_RESET;
		end
	end

	// Updated on the write edge, so the next fetch already sees it.
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			tb_valid_out <= {TB_ENTRIES{1'b0}};
			tb_global_out <= {TB_ENTRIES{1'b0}};
			next_victim_pointer_out <= `CIG_TB_PTR_RESET;
		end else begin
			tb_valid_out <= nxt_tb_valid;
			tb_global_out <= nxt_tb_global;
			next_victim_pointer_out <= nxt_victim;
		end
	end

	// Read multiplexer; write-only and unknown selects read zero.
	// Registered read data keep the answer steady until the next read strobe.
	always @* begin
		nxt_rdata = 64'h0000_0000_0000_0000;
		case (ipr_sel_in)
			`CIG_SEL_SERIAL_IN: begin
				nxt_rdata[`CIG_SERIAL_IN_BIT] = serial_in_bit_ff;
			end
			`CIG_SEL_MODE_STATUS: begin
				nxt_rdata[`CIG_MODE_HI_BIT] = cur_mode_out[1];
				nxt_rdata[`CIG_MODE_LO_BIT] = cur_mode_out[0];
			end
			`CIG_SEL_TRAP_SUMMARY: begin
				nxt_rdata[`CIG_SUM_MASK_BIT] = wmask_ff[mask_ptr_ff];
				nxt_rdata[`CIG_SUM_FLAG_HI:`CIG_SUM_FLAG_LO] = trap_sum_ff;
				nxt_rdata[`CIG_SUM_SWC_BIT] = swc_ff;
			end
			`CIG_SEL_IRQ_REQUEST: begin
				nxt_rdata[`CIG_IRR_SERIAL_BIT] = serial_req_ff;
				nxt_rdata[`CIG_IRR_PC0_BIT] = pc0_req_ff;
				nxt_rdata[`CIG_IRR_PC1_BIT] = pc1_req_ff;
				nxt_rdata[`CIG_IRR_CRD_BIT] = crd_req_ff;
			end
			default: begin
				nxt_rdata = 64'h0000_0000_0000_0000;
			end
		endcase
	end

	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			ipr_rdata_out <= 64'h0000_0000_0000_0000;
			ipr_rd_valid_out <= 1'b0;
		end else begin
			// The valid pulse follows every read strobe, even of write-only selects.
			ipr_rd_valid_out <= ipr_rd_en_in;
			if (ipr_rd_en_in)
				ipr_rdata_out <= nxt_rdata;
		end
	end
endmodule

// ### tb/cig_ipr_asserts.sv
module cig_ipr_asserts #(
	parameter TB_ENTRIES = 12
) (
	// Clock, reset and register port.
	input wire clk_sys_in,
	input wire rst_in,
	input wire ipr_wr_en_in,
	input wire ipr_rd_en_in,
	input wire [3:0] ipr_sel_in,
	input wire [63:0] ipr_wdata_in,
	input wire [63:0] ipr_rdata_out,
	input wire ipr_rd_valid_out,
	// Interrupts.
	input wire serial_irq_enable_in,
	input wire serial_irq_out,
	input wire crd_event_in,
	input wire corrected_err_irq_status_out,
	// Translation buffer and mode.
	input wire [TB_ENTRIES-1:0] tb_valid_out,
	input wire [TB_ENTRIES-1:0] tb_global_out,
	input wire [3:0] next_victim_pointer_out,
	input wire [1:0] cur_mode_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	wire inv_all = ipr_wr_en_in && (ipr_sel_in == 4'h2 || ipr_sel_in == 4'h4);
	wire crd_clr = ipr_wr_en_in && ipr_sel_in == 4'h0 && !ipr_wdata_in[2];
	wire [1:0] mode_wd = ipr_wdata_in[4:3];
	property p_inv_all;
		inv_all |=> tb_valid_out == '0 && next_victim_pointer_out == 4'h0;
	endproperty
	a_inv_all: assert property (p_inv_all) else $error("entries survive invalidate");
	property p_inv_ng;
		ipr_wr_en_in && ipr_sel_in == 4'h3
			|=> tb_valid_out == ($past(tb_valid_out) & $past(tb_global_out));
	endproperty
	a_inv_ng: assert property (p_inv_ng) else $error("non-global invalidate wrong");
	property p_mode_wr;
		ipr_wr_en_in && ipr_sel_in == 4'h5 |=> cur_mode_out == $past(mode_wd);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
	property p_mode_rd;
		ipr_rd_en_in && ipr_sel_in == 4'h5 |=> ipr_rdata_out == {59'h0, cur_mode_out, 3'h0};
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode read wrong");
	property p_crd_clr;
		crd_clr && !crd_event_in |-> ##2 !corrected_err_irq_status_out;
	endproperty
	a_crd_clr: assert property (p_crd_clr) else $error("read error request not cleared");
	property p_crd_hold;
		$fell(corrected_err_irq_status_out) |-> $past(crd_clr, 2);
	endproperty
	a_crd_hold: assert property (p_crd_hold) else $error("read error request dropped");
	property p_crd_set;
		crd_event_in |-> ##2 corrected_err_irq_status_out;
	endproperty
	a_crd_set: assert property (p_crd_set) else $error("read error request missed");
	property p_ser_en;
		serial_irq_out |-> $past(serial_irq_enable_in);
	endproperty
	a_ser_en: assert property (p_ser_en) else $error("serial irq while disabled");
	property p_rd_valid;
		ipr_rd_valid_out == $past(ipr_rd_en_in);
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read answer mistimed");
endmodule

bind cig_ipr_group cig_ipr_asserts #(.TB_ENTRIES(TB_ENTRIES)) u_chk (
	.clk_sys_in, .rst_in, .ipr_wr_en_in, .ipr_rd_en_in, .ipr_sel_in, .ipr_wdata_in,
	.ipr_rdata_out, .ipr_rd_valid_out, .serial_irq_enable_in, .serial_irq_out, .crd_event_in,
	.corrected_err_irq_status_out, .tb_valid_out, .tb_global_out, .next_victim_pointer_out,
	.cur_mode_out
);

// ### tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = '0, rst_in = '1, ipr_wr_en_in = '0, ipr_rd_en_in = '0;
	logic boot_rom_data_pin_in = '0, icache_loaded_in = '0, serial_irq_enable_in = '0;
	logic crd_event_in = '0, pc0_event_in = '0, pc1_event_in = '0, trap_valid_in = '0;
	logic trap_is_float_in = '0, trap_soft_in = '0, tb_fill_in = '0, tb_fill_global_in = '0;
	logic [3:0] ipr_sel_in = '0, next_victim_pointer_out;
	logic [63:0] ipr_wdata_in = '0, ipr_rdata_out, rv, mask = '0;
	logic [5:0] trap_flags_in = '0, trap_dest_in = '0;
	logic ipr_rd_valid_out, serial_irq_status_bit_out, serial_irq_out;
	logic corrected_err_irq_status_out, perf_count0_irq_out, perf_count1_irq_out;
	logic [11:0] tb_valid_out, tb_global_out, ev = '0, eg = '0;
	logic [1:0] cur_mode_out;
	logic [6:0] flags = '0;
	int fail_count = 0, checks_done = 0, ptr = 63, allsoft = 1;

	cig_ipr_group #(.TB_ENTRIES(12)) uut (.clk_sys_in, .rst_in, .ipr_wr_en_in, .ipr_rd_en_in,
		.ipr_sel_in, .ipr_wdata_in, .ipr_rdata_out, .ipr_rd_valid_out, .boot_rom_data_pin_in,
		.icache_loaded_in, .serial_irq_enable_in, .crd_event_in, .pc0_event_in, .pc1_event_in,
		.serial_irq_status_bit_out, .serial_irq_out, .corrected_err_irq_status_out,
		.perf_count0_irq_out, .perf_count1_irq_out, .trap_valid_in, .trap_flags_in,
		.trap_is_float_in, .trap_soft_in, .trap_dest_in, .tb_fill_in, .tb_fill_global_in,
		.tb_valid_out, .tb_global_out, .next_victim_pointer_out, .cur_mode_out);

	always #5 clk_sys_in = ~clk_sys_in;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic w(input int k);
		repeat (k) @(negedge clk_sys_in);
	endtask
	task automatic wr(input logic [3:0] s, input logic [63:0] d);
		@(negedge clk_sys_in);
		ipr_wr_en_in = 1'b1;
		ipr_sel_in = s;
		ipr_wdata_in = d;
		@(negedge clk_sys_in);
		ipr_wr_en_in = 1'b0;
	endtask
	task automatic rd(input logic [3:0] s);
		@(negedge clk_sys_in);
		ipr_rd_en_in = 1'b1;
		ipr_sel_in = s;
		@(negedge clk_sys_in);
		ipr_rd_en_in = 1'b0;
		rv = ipr_rdata_out;
	endtask
	task automatic fill(input int k);
		@(negedge clk_sys_in);
		tb_fill_in = 1'b1;
		tb_fill_global_in = $urandom;
		ev[k] = 1'b1;
		eg[k] = tb_fill_global_in;
		@(negedge clk_sys_in);
		tb_fill_in = 1'b0;
	endtask
	// The model follows the sticky "all float traps had the qualifier" state separately.
	task automatic trap;
		@(negedge clk_sys_in);
		trap_valid_in = 1'b1;
		trap_flags_in = $urandom;
		trap_dest_in = $urandom;
		trap_is_float_in = $urandom;
		trap_soft_in = ($urandom % 4) != 0;
		flags[6:1] = flags[6:1] | trap_flags_in;
		mask[trap_dest_in] = 1'b1;
		if (trap_is_float_in && !trap_soft_in) allsoft = 0;
		if (trap_is_float_in) flags[0] = trap_soft_in && allsoft != 0;
		@(negedge clk_sys_in);
		trap_valid_in = 1'b0;
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(83203));
		repeat (4) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		rst_in = 1'b0;
		chk({tb_valid_out, next_victim_pointer_out, cur_mode_out}, '0);
		rd(4'h1);
		chk(rv, '0);
		repeat (4) begin
			wr(4'h5, {$urandom, $urandom});
			rd(4'h5);
			chk(rv, ipr_wdata_in & 64'h0000_0000_0000_0018);
		end
		for (int k = 0; k < 7; k++) fill(k);
		chk({tb_valid_out, tb_global_out, next_victim_pointer_out}, {ev, eg, 4'h7});
		wr(4'h3, {$urandom, $urandom});
		chk(tb_valid_out, ev & eg);
		ev = ev & eg;
		for (int s = 2; s <= 4; s += 2) begin
			for (int k = 0; k < 3; k++) fill(k);
			wr(s[3:0], {$urandom, $urandom});
			ev = '0;
			chk({tb_valid_out, next_victim_pointer_out}, '0);
		end
		repeat (10) trap();
		// Mask bits from before the write must still drain after it.
		wr(4'h6, {$urandom, $urandom});
		flags = '0;
		allsoft = 1;
		repeat (12) trap();
		repeat (65) begin
			w(2);
			rd(4'h6);
			chk({rv[33], rv[8:2]}, {mask[ptr], flags});
			mask[ptr] = 1'b0;
			ptr = (ptr + 63) % 64;
		end
		icache_loaded_in = 1'b1;
		w(5);
		boot_rom_data_pin_in = 1'b1;
		w(8);
		chk({serial_irq_status_bit_out, serial_irq_out}, 2'h2);
		rd(4'h1);
		chk(rv, 64'h0000_0000_0000_0001);
		serial_irq_enable_in = 1'b1;
		w(3);
		chk(serial_irq_out, 1'b1);
		wr(4'h0, {$urandom, $urandom} | 64'h0000_0000_0000_0007);
		w(2);
		chk(serial_irq_status_bit_out, 1'b0);
		boot_rom_data_pin_in = 1'b0;
		w(8);
		for (int k = 0; k < 3; k++) begin
			crd_event_in = 1'b1;
			pc0_event_in = 1'b1;
			pc1_event_in = 1'b1;
			w(1);
			crd_event_in = 1'b0;
			pc0_event_in = 1'b0;
			pc1_event_in = 1'b0;
			w(3);
			rd(4'h7);
			chk(rv, (k == 0 ? 64'h0000_0000_0000_2310 : 64'h0000_0000_0000_0310));
			wr(4'h0, ~(64'h0000_0000_0000_0001 << (2 - k)));
			w(2);
			chk({corrected_err_irq_status_out, perf_count0_irq_out, perf_count1_irq_out,
				serial_irq_status_bit_out}, {k != 0, k != 1, k != 2, 1'b0});
		end
		tally_and_finish();
	end
endmodule
